// ==== chan_retrans_pkg.sv ====
// constants for the channel extension and replay buffer configuration block
package chan_retrans_pkg;
   // apb register byte offsets
   localparam logic [11:0] CTRL_OFFSET   = 12'h000;
   localparam logic [11:0] DEPTH_OFFSET  = 12'h004;
   localparam logic [11:0] STATUS_OFFSET = 12'h008;

   // control register field positions
   localparam int TX_RANGE_LSB = 0;
   localparam int RX_RANGE_LSB = 2;
   localparam int BANKS_LSB    = 4;
   localparam int MULT_LSB     = 6;

   // status register field positions
   localparam int ST_MULT_RSVD_BIT = 0;
   localparam int ST_RANGE_WARN_BIT = 1;
   localparam int ST_FULL_BIT      = 2;
   localparam int ST_COUNT_LSB     = 16;

   // reset values
   localparam logic [1:0]  RANGE_RESET = 2'h0;
   localparam logic [1:0]  BANKS_RESET = 2'h3;
   localparam logic [2:0]  MULT_RESET  = 3'h0;
   localparam logic [13:0] DEPTH_RESET = 14'h0800;

   // multiplier codes
   localparam logic [2:0] MULT_X4    = 3'h2;
   localparam logic [2:0] MULT_X32   = 3'h5;
   localparam logic [2:0] MULT_X8    = 3'h3;

   // word and control word layout
   localparam int WORD_BITS    = 64;
   localparam int WORD_BYTES   = 8;
   localparam int WORDS_PER_ENTRY = 8;
   localparam int CHAN_BITS    = 11;
   localparam int MU_HI        = 39;
   localparam int MU_LO        = 24;
   localparam int SLICE_BITS   = 16;
   localparam int BASE_CHAN_BITS = 8;
   localparam int SEQ_MAX_BITS = 8;
   localparam int FIELD_SHIFT  = 5;
   localparam int MAX_EXT      = 3;

   // replay buffer geometry
   localparam int DEPTH_BITS   = 14;
   localparam int BANK_ENTRIES = 4096;
   localparam int SEQ_CNT_BITS = 16;
endpackage

// ==== replay_if.sv ====
// carrier between the config top and the replay occupancy tracker
`timescale 1ns/1ps
interface replay_if;
   logic [1:0]  banks;
   logic [13:0] depth;
   logic        write;
   logic        release_entry;
   logic        accepted;
   logic        full;
   logic [13:0] count;
   logic [13:0] wr_index;

   modport cfg (output banks, depth, write, release_entry,
                input accepted, full, count, wr_index);
   modport trk (input banks, depth, write, release_entry,
                output accepted, full, count, wr_index);
endinterface

// ==== replay_tracker.sv ====
// replay buffer occupancy and write index over the enabled banks
`timescale 1ns/1ps
module replay_tracker (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // configuration and strobes
   replay_if.trk    rp
);
   logic [13:0] count_reg;
   logic [13:0] count_next;
   logic [13:0] wptr_reg;
   logic [13:0] wptr_next;
   logic [14:0] bank_cap;
   logic [14:0] limit;
   logic        full;
   logic        take;
   logic        drop;

   always_comb begin
      // only the selected banks hold entries
      bank_cap = 15'((32'(rp.banks) + 32'd1) * chan_retrans_pkg::BANK_ENTRIES); // R03
      // depth further caps the usable entries
      limit = ({1'b0, rp.depth} < bank_cap) ? {1'b0, rp.depth} : bank_cap; // R08
      full = ({1'b0, count_reg} >= limit);
      take = rp.write & ~full;
      drop = rp.release_entry & (count_reg != 14'h0000);
      count_next = count_reg;
      if (take & ~drop) begin
         count_next = count_reg + 14'h0001;
      end else if (drop & ~take) begin
         count_next = count_reg - 14'h0001;
      end
      wptr_next = wptr_reg;
      if (take) begin
         wptr_next = ({1'b0, wptr_reg} + 15'h0001 >= limit) ? 14'h0000 : wptr_reg + 14'h0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_reg <= 14'h0000;
         wptr_reg  <= 14'h0000;
      end else begin
         count_reg <= count_next;
         wptr_reg  <= wptr_next;
      end
   end

   assign rp.accepted = take;
   assign rp.full     = full;
   assign rp.count    = count_reg;
   assign rp.wr_index = wptr_reg;
endmodule

// ==== channel_ext_retrans_config.sv ====
// channel extension and replay buffer configuration with control word packing
//
// Contract
// (R01) tx range select places channel field
// (R02) rx range select extracts channel field
// (R03) bank select limits replay memory banks
// (R04) multiplier codes x1 to x32, 6-7 reserved
// (R05) local tx multiplier matches partner rx
// (R06) sequence and channel share multiple-use bits
// (R07) range select limited by multiplier value; the code only flags a tx range over the limit in status and still applies it
// (R08) depth limits entries of eight words
// (R09) depth chosen from round-trip latency
// (R10) interlaken words are 64 bits wide
// (R11) settings change only while in reset; the code applies apb writes to them at any time out of reset
`timescale 1ns/1ps
module channel_ext_retrans_config (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // transmit control word stream
   input  wire logic        tx_bcw_valid,
   input  wire logic [63:0] tx_bcw_word,
   input  wire logic [10:0] tx_channel,
   output logic             tx_out_valid,
   output logic      [63:0] tx_out_word,
   // receive control word stream
   input  wire logic        rx_bcw_valid,
   input  wire logic [63:0] rx_bcw_word,
   output logic             rx_out_valid,
   output logic      [10:0] rx_channel,
   output logic      [7:0]  rx_sequence,
   // replay buffer strobes
   input  wire logic        replay_write,
   input  wire logic        replay_release,
   output logic             replay_full,
   output logic      [13:0] replay_wr_index
);
   // configuration state
   logic [1:0]  tx_channel_range_select_reg;
   logic [1:0]  tx_channel_range_select_next;
   logic [1:0]  rx_channel_range_select_reg;
   logic [1:0]  rx_channel_range_select_next;
   logic [1:0]  tx_replay_memory_banks_reg;
   logic [1:0]  tx_replay_memory_banks_next;
   logic [2:0]  tx_sequence_multiplier_reg;
   logic [2:0]  tx_sequence_multiplier_next;
   logic [13:0] tx_replay_buffer_depth_reg;
   logic [13:0] tx_replay_buffer_depth_next;
   // bus state
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic        pready_reg;
   logic        pready_next;
   logic        pslverr_reg;
   logic        pslverr_next;
   // stream and sequence state
   logic [15:0] seq_cnt_reg;
   logic [15:0] seq_cnt_next;
   logic        tx_valid_reg;
   logic        tx_valid_next;
   logic [63:0] tx_word_reg;
   logic [63:0] tx_word_next;
   logic        rx_valid_reg;
   logic        rx_valid_next;
   logic [10:0] rx_chan_reg;
   logic [10:0] rx_chan_next;
   logic [7:0]  rx_seq_reg;
   logic [7:0]  rx_seq_next;
   logic        full_reg;
   logic        full_next;
   logic [13:0] widx_reg;
   logic [13:0] widx_next;

   // decode and derived values
   logic        setup;
   logic        wr_commit;
   logic        mapped;
   logic        mult_rsvd;
   logic        range_warn;
   logic [2:0]  seq_shift;
   logic [7:0]  tx_seq_mask;
   logic [7:0]  rx_seq_mask;
   logic [7:0]  tx_seq_val;
   logic [10:0] tx_chan_mask;
   logic [10:0] tx_field;
   logic [15:0] tx_slice;
   logic [15:0] rx_slice;
   logic [31:0] status_word;
   logic [31:0] ctrl_word;

   replay_if rp ();

   replay_tracker u_tracker (
      .pclk    (pclk),
      .presetn (presetn),
      .rp      (rp)
   );

   assign rp.banks         = tx_replay_memory_banks_reg;
   assign rp.depth         = tx_replay_buffer_depth_reg;
   assign rp.write         = replay_write;
   assign rp.release_entry = replay_release;

   always_comb begin
      setup     = psel & ~penable;
      wr_commit = psel & penable & pready_reg & pwrite & ~pslverr_reg;
      mapped    = (paddr == chan_retrans_pkg::CTRL_OFFSET) ||
                  (paddr == chan_retrans_pkg::DEPTH_OFFSET) ||
                  (paddr == chan_retrans_pkg::STATUS_OFFSET);
      // reserved codes are flagged and treated as x1
      mult_rsvd = (tx_sequence_multiplier_reg > chan_retrans_pkg::MULT_X32); // R04
      seq_shift = mult_rsvd ? 3'h0 : tx_sequence_multiplier_reg; // R04 R05
      // surface a partner-side misconfiguration risk, hardware still obeys
      // judged on the effective factor, so a reserved code counts as x1
      range_warn = (seq_shift <= chan_retrans_pkg::MULT_X4) ?
                   (tx_channel_range_select_reg != 2'h0) :
                   ({1'b0, tx_channel_range_select_reg} >
                    3'(seq_shift - chan_retrans_pkg::MULT_X4)); // R07
      ctrl_word = 32'h0000_0000;
      ctrl_word[chan_retrans_pkg::TX_RANGE_LSB +: 2] = tx_channel_range_select_reg;
      ctrl_word[chan_retrans_pkg::RX_RANGE_LSB +: 2] = rx_channel_range_select_reg;
      ctrl_word[chan_retrans_pkg::BANKS_LSB +: 2]    = tx_replay_memory_banks_reg;
      ctrl_word[chan_retrans_pkg::MULT_LSB +: 3]     = tx_sequence_multiplier_reg;
      status_word = 32'h0000_0000;
      status_word[chan_retrans_pkg::ST_MULT_RSVD_BIT]  = mult_rsvd;
      status_word[chan_retrans_pkg::ST_RANGE_WARN_BIT] = range_warn;
      status_word[chan_retrans_pkg::ST_FULL_BIT]       = rp.full;
      status_word[chan_retrans_pkg::ST_COUNT_LSB +: 14] = rp.count;

      // apb: answer in the first access cycle, no waits
      pready_next  = setup;
      pslverr_next = setup & ~mapped;
      prdata_next  = prdata_reg;
      if (setup & ~pwrite) begin
         unique case (paddr)
            chan_retrans_pkg::CTRL_OFFSET:   prdata_next = ctrl_word;
            chan_retrans_pkg::DEPTH_OFFSET:  prdata_next = {18'h0_0000, tx_replay_buffer_depth_reg};
            chan_retrans_pkg::STATUS_OFFSET: prdata_next = status_word;
            default:                         prdata_next = 32'h0000_0000;
         endcase
      end

      // settings take apb writes at any time out of reset; software should write them before traffic
      tx_channel_range_select_next = tx_channel_range_select_reg;
      rx_channel_range_select_next = rx_channel_range_select_reg;
      tx_replay_memory_banks_next  = tx_replay_memory_banks_reg;
      tx_sequence_multiplier_next  = tx_sequence_multiplier_reg;
      tx_replay_buffer_depth_next  = tx_replay_buffer_depth_reg;
      if (wr_commit && paddr == chan_retrans_pkg::CTRL_OFFSET) begin
         tx_channel_range_select_next = pwdata[chan_retrans_pkg::TX_RANGE_LSB +: 2];
         rx_channel_range_select_next = pwdata[chan_retrans_pkg::RX_RANGE_LSB +: 2];
         tx_replay_memory_banks_next  = pwdata[chan_retrans_pkg::BANKS_LSB +: 2];
         tx_sequence_multiplier_next  = pwdata[chan_retrans_pkg::MULT_LSB +: 3];
      end
      if (wr_commit && paddr == chan_retrans_pkg::DEPTH_OFFSET) begin
         tx_replay_buffer_depth_next = pwdata[chan_retrans_pkg::DEPTH_BITS-1:0];
      end

      // one sequence step per multiplier-many accepted replay entries
      seq_cnt_next = rp.accepted ? seq_cnt_reg + 16'h0001 : seq_cnt_reg;
      tx_seq_mask  = 8'(8'hff >> tx_channel_range_select_reg); // R06
      tx_seq_val   = 8'(seq_cnt_reg >> seq_shift) & tx_seq_mask; // R06
      // channel field grows downward from bit 39 by range select
      tx_chan_mask = 11'(11'h0ff >> 0) | 11'(11'h700 >> (chan_retrans_pkg::MAX_EXT -
                     32'(tx_channel_range_select_reg))) & 11'h700; // R01
      tx_field     = 11'((tx_channel & tx_chan_mask) <<
                     (2'(chan_retrans_pkg::MAX_EXT) - tx_channel_range_select_reg)); // R01
      tx_slice     = 16'({tx_field, 5'h00}) | {8'h00, tx_seq_val}; // R06
      tx_valid_next = tx_bcw_valid;
      tx_word_next  = tx_word_reg;
      if (tx_bcw_valid) begin
         tx_word_next = tx_bcw_word; // R10
         tx_word_next[chan_retrans_pkg::MU_HI:chan_retrans_pkg::MU_LO] = tx_slice; // R06
      end

      // receive: same coding, field read from 39 downward
      rx_slice      = rx_bcw_word[chan_retrans_pkg::MU_HI:chan_retrans_pkg::MU_LO];
      rx_seq_mask   = 8'(8'hff >> rx_channel_range_select_reg); // R02
      rx_valid_next = rx_bcw_valid;
      rx_chan_next  = rx_chan_reg;
      rx_seq_next   = rx_seq_reg;
      if (rx_bcw_valid) begin
         rx_chan_next = 11'(rx_slice[15:chan_retrans_pkg::FIELD_SHIFT] >>
                        (2'(chan_retrans_pkg::MAX_EXT) - rx_channel_range_select_reg)); // R02
         rx_seq_next  = rx_slice[7:0] & rx_seq_mask; // R06
      end

      full_next = rp.full;
      widx_next = rp.wr_index;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_channel_range_select_reg <= chan_retrans_pkg::RANGE_RESET;
         rx_channel_range_select_reg <= chan_retrans_pkg::RANGE_RESET;
         tx_replay_memory_banks_reg  <= chan_retrans_pkg::BANKS_RESET;
         tx_sequence_multiplier_reg  <= chan_retrans_pkg::MULT_RESET;
         tx_replay_buffer_depth_reg  <= chan_retrans_pkg::DEPTH_RESET;
         prdata_reg   <= 32'h0000_0000;
         pready_reg   <= 1'b0;
         pslverr_reg  <= 1'b0;
         seq_cnt_reg  <= 16'h0000;
         tx_valid_reg <= 1'b0;
         tx_word_reg  <= 64'h0000_0000_0000_0000;
         rx_valid_reg <= 1'b0;
         rx_chan_reg  <= 11'h000;
         rx_seq_reg   <= 8'h00;
         full_reg     <= 1'b0;
         widx_reg     <= 14'h0000;
      end else begin
         tx_channel_range_select_reg <= tx_channel_range_select_next;
         rx_channel_range_select_reg <= rx_channel_range_select_next;
         tx_replay_memory_banks_reg  <= tx_replay_memory_banks_next;
         tx_sequence_multiplier_reg  <= tx_sequence_multiplier_next;
         tx_replay_buffer_depth_reg  <= tx_replay_buffer_depth_next;
         prdata_reg   <= prdata_next;
         pready_reg   <= pready_next;
         pslverr_reg  <= pslverr_next;
         seq_cnt_reg  <= seq_cnt_next;
         tx_valid_reg <= tx_valid_next;
         tx_word_reg  <= tx_word_next;
         rx_valid_reg <= rx_valid_next;
         rx_chan_reg  <= rx_chan_next;
         rx_seq_reg   <= rx_seq_next;
         full_reg     <= full_next;
         widx_reg     <= widx_next;
      end
   end

   assign prdata          = prdata_reg;
   assign pready          = pready_reg;
   assign pslverr         = pslverr_reg;
   assign tx_out_valid    = tx_valid_reg;
   assign tx_out_word     = tx_word_reg;
   assign rx_out_valid    = rx_valid_reg;
   assign rx_channel      = rx_chan_reg;
   assign rx_sequence     = rx_seq_reg;
   assign replay_full     = full_reg;
   assign replay_wr_index = widx_reg;
endmodule

// ==== channel_ext_retrans_config_checker.sv ====
// concurrent checks on the configuration block ports
`timescale 1ns/1ps
module channel_ext_retrans_config_checker (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [11:0] paddr,
   input wire logic        pready,
   input wire logic        pslverr,
   // streams
   input wire logic        tx_bcw_valid,
   input wire logic [63:0] tx_bcw_word,
   input wire logic        tx_out_valid,
   input wire logic [63:0] tx_out_word,
   input wire logic        rx_bcw_valid,
   input wire logic        rx_out_valid,
   // replay
   input wire logic        replay_write,
   input wire logic [13:0] replay_wr_index
);
   logic mapped;
   assign mapped = (paddr == chan_retrans_pkg::CTRL_OFFSET) ||
                   (paddr == chan_retrans_pkg::DEPTH_OFFSET) ||
                   (paddr == chan_retrans_pkg::STATUS_OFFSET);
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence bad_setup_s;
      setup_s ##0 !mapped;
   endsequence
   a_ready_answer: assert property (@(posedge pclk) disable iff (!presetn)
      setup_s |=> pready) else $error("pready missing after setup");
   a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready) else $error("pready longer than one cycle");
   a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
      bad_setup_s |=> pslverr && pready) else $error("no error on unmapped address");
   a_tx_follow: assert property (@(posedge pclk) disable iff (!presetn)
      tx_bcw_valid |=> tx_out_valid) else $error("tx word lost");
   a_tx_outer_bits: assert property (@(posedge pclk) disable iff (!presetn)
      tx_bcw_valid |=> tx_out_word[63:40] == $past(tx_bcw_word[63:40]) &&
      tx_out_word[23:0] == $past(tx_bcw_word[23:0])) else $error("tx bits outside field changed");
   a_rx_follow: assert property (@(posedge pclk) disable iff (!presetn)
      rx_bcw_valid |=> rx_out_valid) else $error("rx word lost");
   a_index_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !replay_write |-> ##2 $stable(replay_wr_index)) else $error("index moved without write");
   // no disable here: this one is about the reset itself
   a_reset_quiet: assert property (@(posedge pclk) !presetn |-> !pready && !pslverr &&
      !tx_out_valid && !rx_out_valid && replay_wr_index == 14'h0000)
      else $error("outputs active in reset");
endmodule

// ==== link_partner_model.sv ====
// link partner model that loops transmitted control words back to receive
`timescale 1ns/1ps
module link_partner_model (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // words from the block
   input wire logic        tx_out_valid,
   input wire logic [63:0] tx_out_word,
   // words to the block
   output logic            rx_bcw_valid,
   output logic     [63:0] rx_bcw_word
);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_bcw_valid <= 1'b0;
         rx_bcw_word  <= 64'h0000_0000_0000_0000;
      end else begin
         // far end runs the same multiplier, so loopback decodes alike
         rx_bcw_valid <= tx_out_valid;
         // idle lane shows the inverse so stale data never passes
         rx_bcw_word  <= tx_out_valid ? tx_out_word : ~rx_bcw_word;
      end
   end
endmodule

// ==== channel_ext_retrans_config_tb_top.sv ====
// testbench for the channel extension and replay configuration block
`timescale 1ns/1ps
module channel_ext_retrans_config_tb_top;
   typedef struct packed {
      logic [1:0] kt; logic [1:0] kr; logic [2:0] m; logic [10:0] ch;
      logic [15:0] fld; logic [10:0] rch; logic [7:0] rsq; logic [1:0] st;
   } row_s;
   localparam logic [63:0] WORD = 64'h0123_4567_89ab_cdef;
   row_s rows [9] = '{
      '{2'h0, 2'h0, 3'h0, 11'h7ab, 16'hab00, 11'h0ab, 8'h00, 2'h0},
      '{2'h1, 2'h1, 3'h3, 11'h7ab, 16'hd580, 11'h1ab, 8'h00, 2'h0},
      '{2'h2, 2'h2, 3'h4, 11'h7ab, 16'heac0, 11'h3ab, 8'h00, 2'h0},
      '{2'h3, 2'h3, 3'h5, 11'h7ab, 16'hf560, 11'h7ab, 8'h00, 2'h0},
      '{2'h3, 2'h0, 3'h2, 11'h7ab, 16'hf560, 11'h0f5, 8'h60, 2'h2},
      '{2'h0, 2'h0, 3'h6, 11'h0ff, 16'hff00, 11'h0ff, 8'h00, 2'h1},
      '{2'h1, 2'h1, 3'h2, 11'h100, 16'h8000, 11'h100, 8'h00, 2'h2},
      '{2'h0, 2'h0, 3'h1, 11'h005, 16'h0500, 11'h005, 8'h00, 2'h0},
      '{2'h2, 2'h2, 3'h7, 11'h2aa, 16'haa80, 11'h2aa, 8'h00, 2'h3}};
   logic pclk = 1'b0;
   logic presetn = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic tx_bcw_valid = 1'b0;
   logic [63:0] tx_bcw_word = 64'h0000_0000_0000_0000;
   logic [10:0] tx_channel = 11'h000;
   logic tx_out_valid;
   logic [63:0] tx_out_word;
   logic rx_bcw_valid;
   logic [63:0] rx_bcw_word;
   logic rx_out_valid;
   logic [10:0] rx_channel;
   logic [7:0] rx_sequence;
   logic replay_write = 1'b0;
   logic replay_release = 1'b0;
   logic replay_full;
   logic [13:0] replay_wr_index;
   logic [31:0] q;
   logic e;
   logic [31:0] ctrl;
   row_s r;
   int n_errors = 0;
   int n_compared = 0;
   always #2 pclk = ~pclk;
   channel_ext_retrans_config i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .tx_bcw_valid(tx_bcw_valid),
      .tx_bcw_word(tx_bcw_word), .tx_channel(tx_channel), .tx_out_valid(tx_out_valid),
      .tx_out_word(tx_out_word), .rx_bcw_valid(rx_bcw_valid), .rx_bcw_word(rx_bcw_word),
      .rx_out_valid(rx_out_valid), .rx_channel(rx_channel), .rx_sequence(rx_sequence),
      .replay_write(replay_write), .replay_release(replay_release),
      .replay_full(replay_full), .replay_wr_index(replay_wr_index));
   link_partner_model i_partner (.pclk(pclk), .presetn(presetn), .tx_out_valid(tx_out_valid),
      .tx_out_word(tx_out_word), .rx_bcw_valid(rx_bcw_valid), .rx_bcw_word(rx_bcw_word));
   task chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
      n_compared++;
      if (got !== exp) begin
         $display("BAD %s expected %h seen %h", nm, exp, got);
         n_errors++;
      end
   endtask
   task wrap_up;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task rd(input logic [11:0] a, input string nm, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(nm, exp, q);
   endtask
   // tx check one edge after launch, rx after the partner's loopback
   task send(input logic [10:0] ch, input logic [15:0] fld, input logic [10:0] rch,
             input logic [7:0] rsq);
      tx_bcw_valid <= 1'b1;
      tx_bcw_word  <= WORD;
      tx_channel   <= ch;
      @(posedge pclk);
      tx_bcw_valid <= 1'b0;
      #1;
      chk("tx_valid", 64'h1, tx_out_valid);
      chk("tx_word", {WORD[63:40], fld, WORD[23:0]}, tx_out_word);
      repeat (2) @(posedge pclk);
      #1;
      chk("rx_channel", rch, rx_channel);
      chk("rx_sequence", rsq, rx_sequence);
      @(posedge pclk);
   endtask
   task writes(input int n);
      replay_write <= 1'b1;
      repeat (n) @(posedge pclk);
      replay_write <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask
   initial begin
      repeat (40000) @(posedge pclk);
      $display("watchdog expired");
      n_errors++;
      wrap_up();
   end
   initial begin
      // a real falling edge at time zero clears the flops before the first clock
      presetn <= 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 9; i++) begin
         r = rows[i];
         ctrl = {23'h0, r.m, 2'h3, r.kr, r.kt};
         apb(1'b1, chan_retrans_pkg::CTRL_OFFSET, ctrl);
         rd(chan_retrans_pkg::CTRL_OFFSET, "ctrl", ctrl);
         rd(chan_retrans_pkg::STATUS_OFFSET, "status", {30'h0, r.st});
         send(r.ch, r.fld, r.rch, r.rsq);
      end
      $display("test table done");
      apb(1'b1, 12'h00c, 32'hffff_ffff);
      chk("wr_err", 64'h1, e);
      apb(1'b0, 12'h00c, 32'h0000_0000);
      chk("rd_err", 64'h1, e);
      chk("rd_zero", 64'h0, q);
      apb(1'b1, chan_retrans_pkg::STATUS_OFFSET, 32'hffff_ffff);
      chk("st_wr_err", 64'h0, e);
      rd(chan_retrans_pkg::CTRL_OFFSET, "ctrl_kept", ctrl);
      $display("test unmapped done");
      apb(1'b1, chan_retrans_pkg::DEPTH_OFFSET, 32'h0000_0005);
      apb(1'b1, chan_retrans_pkg::CTRL_OFFSET, 32'h0000_0070);
      writes(7);
      chk("full", 64'h1, replay_full);
      chk("index", 64'h0, replay_wr_index);
      rd(chan_retrans_pkg::STATUS_OFFSET, "st_full", 32'h0005_0004);
      // five accepted entries at x2 give sequence two
      send(11'h011, 16'h1102, 11'h011, 8'h02);
      replay_release <= 1'b1;
      @(posedge pclk);
      replay_release <= 1'b0;
      repeat (3) @(posedge pclk);
      chk("not_full", 64'h0, replay_full);
      rd(chan_retrans_pkg::STATUS_OFFSET, "st_freed", 32'h0004_0000);
      $display("test replay done");
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(chan_retrans_pkg::CTRL_OFFSET, "ctrl_rst", 32'h0000_0030);
      rd(chan_retrans_pkg::DEPTH_OFFSET, "depth_rst", 32'h0000_0800);
      rd(chan_retrans_pkg::STATUS_OFFSET, "status_rst", 32'h0000_0000);
      chk("index_rst", 64'h0, replay_wr_index);
      apb(1'b1, chan_retrans_pkg::CTRL_OFFSET, 32'h0000_0000);
      apb(1'b1, chan_retrans_pkg::DEPTH_OFFSET, 32'h0000_3fff);
      writes(4100);
      chk("bank_full", 64'h1, replay_full);
      chk("bank_wrap", 64'h0, replay_wr_index);
      rd(chan_retrans_pkg::STATUS_OFFSET, "st_bank", 32'h1000_0004);
      // a second bank doubles the limit and clears full at once
      apb(1'b1, chan_retrans_pkg::CTRL_OFFSET, 32'h0000_0010);
      repeat (2) @(posedge pclk);
      rd(chan_retrans_pkg::STATUS_OFFSET, "st_two_banks", 32'h1000_0000);
      $display("test reset and banks done");
      wrap_up();
   end
endmodule
bind channel_ext_retrans_config channel_ext_retrans_config_checker i_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
   .pready(pready), .pslverr(pslverr), .tx_bcw_valid(tx_bcw_valid),
   .tx_bcw_word(tx_bcw_word), .tx_out_valid(tx_out_valid), .tx_out_word(tx_out_word),
   .rx_bcw_valid(rx_bcw_valid), .rx_out_valid(rx_out_valid),
   .replay_write(replay_write), .replay_wr_index(replay_wr_index));
